// ==== logic/dart_bank_timer.sv ====
// one bank of the memory: open state, row age, auto-precharge, recovery
// assumes command pulses are one cycle and already bank-decoded
`default_nettype none
module dart_bank_timer #(
  parameter int AP_RD = 2,
  parameter int AP_WR = 5,
  parameter int RAS = 5,
  parameter int RP = 2,
  parameter int RPALL = 2
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic act,
  input wire logic rd_ap,
  input wire logic wr_ap,
  input wire logic pre,
  input wire logic pre_all,
  output logic active,
  output logic idle,
  output logic ap_fire
);
  import dart_pkg::*;

  logic [CNT_W-1:0] ras_q;
  logic [CNT_W-1:0] ap_q;
  logic [CNT_W-1:0] rp_q;
  logic pend_q;
  logic fire;

  // internal precharge once burst wait and row age are both met
  assign fire = pend_q && (ap_q == '0) && (ras_q == '0);

  // row age since activate
  always_ff @(posedge clk or posedge rst)
    if (rst)
      ras_q <= '0;
    else if (act)
      ras_q <= CNT_W'(RAS);
    else if (ras_q != '0)
      ras_q <= ras_q - 1'b1;

  // pending auto-precharge countdown
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      pend_q <= 1'b0;
      ap_q <= '0;
    end
    else if (rd_ap || wr_ap)
    begin
      pend_q <= 1'b1;
      ap_q <= rd_ap ? CNT_W'(AP_RD) : CNT_W'(AP_WR);
    end
    else if (fire || pre)
      pend_q <= 1'b0;
    else if (ap_q != '0)
      ap_q <= ap_q - 1'b1;

  // open flag: burst without auto-precharge leaves the row open
  always_ff @(posedge clk or posedge rst)
    if (rst)
      active <= 1'b0;
    else if (act)
      active <= 1'b1;
    else if (pre || fire)
      active <= 1'b0;

  // precharge period from the latest precharge of either kind
  always_ff @(posedge clk or posedge rst)
    if (rst)
      rp_q <= '0;
    else if (pre)
      rp_q <= pre_all ? CNT_W'(RPALL) : CNT_W'(RP);
    else if (fire)
      rp_q <= CNT_W'(RP);
    else if (rp_q != '0)
      rp_q <= rp_q - 1'b1;

  // status flags
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      idle <= 1'b1;
      ap_fire <= 1'b0;
    end
    else
    begin
      idle <= !active && (rp_q == '0);
      ap_fire <= fire;
    end
endmodule
`default_nettype wire

// ==== logic/dart_ctrl_end.sv ====
// controller end: turns user requests into timed memory commands
// assumes the memory samples the pins on the next rising edge
`default_nettype none
module dart_ctrl_end #(
  parameter int CL = dart_pkg::CL_DEF,
  parameter int AL = dart_pkg::AL_DEF,
  parameter int BL = dart_pkg::BL_DEF,
  parameter int WR = dart_pkg::WR_DEF
) (
  input wire logic clk,
  input wire logic rst,
  dart_if.ctrl link,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic req_ap,
  input wire logic [dart_pkg::BANK_W-1:0] req_bank,
  input wire logic [dart_pkg::ADDR_W-1:0] req_row,
  input wire logic [dart_pkg::COL_W-1:0] req_col,
  output logic req_ack,
  output logic col_issued,
  output logic [dart_pkg::DEBT_W-1:0] refresh_debt
);
  import dart_pkg::*;

  localparam int WL = AL + CL - 1;
  localparam int BL2 = BL / 2;
  localparam int RTP_EFF = (RTP_CYC > RTP_FLOOR) ? RTP_CYC : RTP_FLOOR;
  localparam int RD_PRE = AL + BL2 + RTP_EFF - RTP_OFFSET;
  localparam int WR_PRE = WL + BL2 + WRA_CYC;
  localparam int WRAP_PRE = WL + BL2 + WR;
  localparam int WRAP_ACT = WRAP_PRE + RP_CYC;
  localparam int RDAP_ACT = RD_PRE + RP_CYC;
  localparam int WR_TO_RD = CL - 1 + BL2 + WTR_CYC;
  localparam int RD_TO_WR = BL2 + RD_WR_EXTRA;

  if (WR < WR_MIN || WR > WR_MAX || WR * TCK_NS < T_WR_NS)
    $error("write recovery setting illegal");
  if (BL != 4 && BL != 8)
    $error("burst length must be 4 or 8");
  if (COL_W > AP_BIT)
    $error("column must fit below the auto-precharge bit");
  if (WRAP_ACT >= (1 << CNT_W) || RFC_CYC >= (1 << CNT_W))
    $error("timing count too wide for counters");

  typedef enum {ST_IDLE, ST_ROW, ST_COL, ST_REF} dart_state_t;
  dart_state_t state_q, state_d;

  logic [NUM_BANKS-1:0] open_q;
  logic [ADDR_W-1:0] row_q [NUM_BANKS];
  logic [CNT_W-1:0] act_blk_q [NUM_BANKS];
  logic [CNT_W-1:0] pre_blk_q [NUM_BANKS];
  logic [CNT_W-1:0] col_blk_q [NUM_BANKS];
  logic [CNT_W-1:0] ap_blk_q [NUM_BANKS];
  logic [CNT_W-1:0] rd_blk_q, wr_blk_q, pre_gap_q;
  logic [REFI_W-1:0] refi_q;
  logic wr_q, ap_q;
  logic [BANK_W-1:0] bank_q;
  logic [ADDR_W-1:0] rrow_q;
  logic [COL_W-1:0] col_q;
  logic iss_act, iss_rd, iss_wr, iss_pre, iss_preall, iss_ref;
  logic any_ap, all_act_ok, all_pre_ok, refi_tick;

  // readiness summaries across banks
  always_comb
  begin
    any_ap = 1'b0;
    all_act_ok = 1'b1;
    all_pre_ok = 1'b1;
    for (int b = 0; b < NUM_BANKS; b++)
    begin
      any_ap = any_ap || (ap_blk_q[b] != '0);
      all_act_ok = all_act_ok && (act_blk_q[b] == '0);
      all_pre_ok = all_pre_ok && (!open_q[b] || pre_blk_q[b] == '0);
    end
  end

  // command sequencer
  always_comb
  begin
    state_d = state_q;
    iss_act = 1'b0;
    iss_rd = 1'b0;
    iss_wr = 1'b0;
    iss_pre = 1'b0;
    iss_preall = 1'b0;
    iss_ref = 1'b0;
    unique case (state_q)
      ST_IDLE:
        if (refresh_debt >= DEBT_W'(POSTED_MAX))
          state_d = ST_REF;
        else if (req_valid)
          state_d = ST_ROW;
        else if (refresh_debt != '0)
          state_d = ST_REF;
      ST_ROW:
        if (open_q[bank_q] && row_q[bank_q] == rrow_q)
          state_d = ST_COL;
        else if (open_q[bank_q])
          iss_pre = (pre_blk_q[bank_q] == '0) && (pre_gap_q == '0);
        else if (act_blk_q[bank_q] == '0)
        begin
          iss_act = 1'b1;
          state_d = ST_COL;
        end
      ST_COL:
        if (col_blk_q[bank_q] == '0 &&
            (wr_q ? wr_blk_q == '0 : rd_blk_q == '0))
        begin
          iss_wr = wr_q;
          iss_rd = !wr_q;
          state_d = ST_IDLE;
        end
      ST_REF:
        if (open_q != '0)
          iss_preall = !any_ap && all_pre_ok && (pre_gap_q == '0);
        else if (all_act_ok)
        begin
          iss_ref = 1'b1;
          state_d = ST_IDLE;
        end
    endcase
  end

  // state and request capture
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      state_q <= ST_IDLE;
      wr_q <= 1'b0;
      ap_q <= 1'b0;
      bank_q <= '0;
      rrow_q <= '0;
      col_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      if (state_q == ST_IDLE && state_d == ST_ROW)
      begin
        wr_q <= req_write;
        ap_q <= req_ap;
        bank_q <= req_bank;
        rrow_q <= req_row;
        col_q <= req_col;
      end
    end

  // per-bank timers: activate and precharge waits keep the longer of old and new
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      open_q <= '0;
      for (int b = 0; b < NUM_BANKS; b++)
      begin
        row_q[b] <= '0;
        act_blk_q[b] <= '0;
        pre_blk_q[b] <= '0;
        col_blk_q[b] <= '0;
        ap_blk_q[b] <= '0;
      end
    end
    else
      for (int b = 0; b < NUM_BANKS; b++)
      begin
        logic [CNT_W-1:0] a, p, c, w;
        logic hit;
        a = (act_blk_q[b] != '0) ? act_blk_q[b] - 1'b1 : '0;
        p = (pre_blk_q[b] != '0) ? pre_blk_q[b] - 1'b1 : '0;
        c = (col_blk_q[b] != '0) ? col_blk_q[b] - 1'b1 : '0;
        w = (ap_blk_q[b] != '0) ? ap_blk_q[b] - 1'b1 : '0;
        hit = (bank_q == BANK_W'(b));
        if (iss_act && hit)
        begin
          open_q[b] <= 1'b1;
          row_q[b] <= rrow_q;
          a = dart_later(a, CNT_W'(RC_CYC));
          p = dart_later(p, CNT_W'(RAS_CYC));
          c = CNT_W'(RCD_CYC);
        end
        if (iss_rd && hit)
        begin
          p = dart_later(p, CNT_W'(RD_PRE));
          if (ap_q)
          begin
            open_q[b] <= 1'b0;
            a = dart_later(a, CNT_W'(RDAP_ACT));
            w = CNT_W'(RD_PRE);
          end
        end
        if (iss_wr && hit)
        begin
          p = dart_later(p, CNT_W'(WR_PRE));
          if (ap_q)
          begin
            open_q[b] <= 1'b0;
            a = dart_later(a, CNT_W'(WRAP_ACT));
            w = CNT_W'(WRAP_PRE);
          end
        end
        if (iss_pre && hit)
        begin
          open_q[b] <= 1'b0;
          a = dart_later(a, CNT_W'(RP_CYC));
        end
        if (iss_preall)
        begin
          open_q[b] <= 1'b0;
          a = dart_later(a, CNT_W'(RPALL_CYC));
        end
        if (iss_ref)
          a = dart_later(a, CNT_W'(RFC_CYC));
        act_blk_q[b] <= a;
        pre_blk_q[b] <= p;
        col_blk_q[b] <= c;
        ap_blk_q[b] <= w;
      end

  // shared column and precharge spacing
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      rd_blk_q <= '0;
      wr_blk_q <= '0;
      pre_gap_q <= '0;
    end
    else
    begin
      if (iss_wr)
      begin
        rd_blk_q <= CNT_W'(WR_TO_RD);
        wr_blk_q <= CNT_W'(BL2);
      end
      else if (iss_rd)
      begin
        rd_blk_q <= CNT_W'(BL2);
        wr_blk_q <= CNT_W'(RD_TO_WR);
      end
      else
      begin
        rd_blk_q <= (rd_blk_q != '0) ? rd_blk_q - 1'b1 : '0;
        wr_blk_q <= (wr_blk_q != '0) ? wr_blk_q - 1'b1 : '0;
      end
      if (iss_pre || iss_preall)
        pre_gap_q <= CNT_W'(PRE_GAP_CYC);
      else if (pre_gap_q != '0)
        pre_gap_q <= pre_gap_q - 1'b1;
    end

  // refresh interval timer and debt; a tick in the issue cycle counts
  assign refi_tick = (refi_q == '0);
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      refi_q <= REFI_W'(REFI_CYC - 1);
      refresh_debt <= '0;
    end
    else
    begin
      refi_q <= refi_tick ? REFI_W'(REFI_CYC - 1) : refi_q - 1'b1;
      if (refi_tick && !iss_ref && refresh_debt != DEBT_W'(POSTED_MAX + 1))
        refresh_debt <= refresh_debt + 1'b1;
      else if (iss_ref && !refi_tick)
        refresh_debt <= refresh_debt - 1'b1;
    end

  // command pins, nop when nothing is issued
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= CMD_DESEL;
      link.addr <= '0;
      link.ba <= '0;
    end
    else
    begin
      {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= CMD_NOP;
      link.addr <= '0;
      link.ba <= bank_q;
      if (iss_act)
      begin
        {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= CMD_ACT;
        link.addr <= rrow_q;
      end
      else if (iss_rd || iss_wr)
      begin
        {link.cs_n, link.ras_n, link.cas_n, link.we_n} <=
          iss_wr ? CMD_WR : CMD_RD;
        link.addr <= {{(ADDR_W - COL_W){1'b0}}, col_q} |
          (ADDR_W'(ap_q) << AP_BIT);
      end
      else if (iss_pre || iss_preall)
      begin
        {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= CMD_PRE;
        link.addr <= ADDR_W'(iss_preall) << AP_BIT;
      end
      else if (iss_ref)
        {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= CMD_REF;
    end

  // user handshake pulses
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      req_ack <= 1'b0;
      col_issued <= 1'b0;
    end
    else
    begin
      req_ack <= (state_q == ST_IDLE) && (state_d == ST_ROW);
      col_issued <= iss_rd || iss_wr;
    end
endmodule
`default_nettype wire

// ==== logic/dart_dram_end.sv ====
// memory end: decodes pins, keeps per-bank timers and refresh row
// assumes the controller keeps every spacing limit on its side
`default_nettype none
module dart_dram_end #(
  parameter int CL = dart_pkg::CL_DEF,
  parameter int AL = dart_pkg::AL_DEF,
  parameter int BL = dart_pkg::BL_DEF,
  parameter int WR = dart_pkg::WR_DEF
) (
  input wire logic clk,
  input wire logic rst,
  dart_if.dram link,
  output logic [dart_pkg::NUM_BANKS-1:0] bank_active,
  output logic [dart_pkg::NUM_BANKS-1:0] bank_idle,
  output logic [dart_pkg::ADDR_W-1:0] refresh_row,
  output logic refresh_busy,
  output logic ap_fired
);
  import dart_pkg::*;

  localparam int WL = AL + CL - 1;
  localparam int BL2 = BL / 2;
  localparam int AP_RD = AL + BL2 +
    ((RTP_CYC > RTP_FLOOR) ? RTP_CYC : RTP_FLOOR) - RTP_OFFSET;
  localparam int AP_WR = WL + BL2 + WR;

  if (WR < WR_MIN || WR > WR_MAX)
    $error("write recovery setting out of range");
  if (BL != 4 && BL != 8)
    $error("burst length must be 4 or 8");
  if (AP_WR >= (1 << CNT_W) || RFC_CYC >= (1 << CNT_W))
    $error("timing count too wide for counters");

  dart_cmd_t cmd;
  logic ap;
  logic [NUM_BANKS-1:0] fire;
  logic [CNT_W-1:0] rfc_q;

  assign cmd = dart_decode({link.cs_n, link.ras_n, link.cas_n, link.we_n});
  assign ap = link.addr[AP_BIT];

  // banks run independently, so other banks work during auto-precharge
  for (genvar b = 0; b < NUM_BANKS; b++)
  begin
    dart_bank_timer #(
      .AP_RD(AP_RD),
      .AP_WR(AP_WR),
      .RAS(RAS_CYC),
      .RP(RP_CYC),
      .RPALL(RPALL_CYC)
    ) u_bank (
      .clk(clk),
      .rst(rst),
      .act(cmd == C_ACT && link.ba == BANK_W'(b)),
      .rd_ap(cmd == C_RD && ap && link.ba == BANK_W'(b)),
      .wr_ap(cmd == C_WR && ap && link.ba == BANK_W'(b)),
      .pre(cmd == C_PRE && (ap || link.ba == BANK_W'(b))),
      .pre_all(cmd == C_PRE && ap),
      .active(bank_active[b]),
      .idle(bank_idle[b]),
      .ap_fire(fire[b])
    );
  end

  // refresh uses its own row counter, address pins ignored
  always_ff @(posedge clk or posedge rst)
    if (rst)
      refresh_row <= '0;
    else if (cmd == C_REF)
      refresh_row <= refresh_row + 1'b1;

  // refresh cycle time; banks stay closed throughout
  always_ff @(posedge clk or posedge rst)
    if (rst)
      rfc_q <= '0;
    else if (cmd == C_REF)
      rfc_q <= CNT_W'(RFC_CYC);
    else if (rfc_q != '0)
      rfc_q <= rfc_q - 1'b1;

  // status outputs
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      refresh_busy <= 1'b0;
      ap_fired <= 1'b0;
    end
    else
    begin
      refresh_busy <= (cmd == C_REF) || (rfc_q > CNT_W'(1));
      ap_fired <= |fire;
    end
endmodule
`default_nettype wire

// ==== logic/dart_if.sv ====
// command and address pins between controller and memory
// assumes both ends sample on the same rising clock edge
`default_nettype none
interface dart_if;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic [dart_pkg::ADDR_W-1:0] addr;
  logic [dart_pkg::BANK_W-1:0] ba;

  modport ctrl (output cs_n, ras_n, cas_n, we_n, addr, ba);
  modport dram (input cs_n, ras_n, cas_n, we_n, addr, ba);
endinterface
`default_nettype wire

// ==== logic/dart_pkg.sv ====
// shared constants, command encodings and helpers for both ends
// assumes one 100 MHz clock shared by controller and memory model
`default_nettype none
package dart_pkg;
  // clock and bus geometry
  localparam int TCK_NS = 10;
  localparam int NUM_BANKS = 8;
  localparam int BANK_W = 3;
  localparam int ADDR_W = 14;
  localparam int COL_W = 10;
  localparam int AP_BIT = 10;
  localparam int CNT_W = 8;
  localparam int REFI_W = 16;
  localparam int DEBT_W = 4;

  // mode defaults
  localparam int CL_DEF = 3;
  localparam int AL_DEF = 0;
  localparam int BL_DEF = 4;
  localparam int WR_DEF = 3;
  localparam int WR_MIN = 2;
  localparam int WR_MAX = 6;

  // analog times in ns
  localparam int T_RP_NS = 15;
  localparam int T_RPALL_NS = 15;
  localparam int T_RAS_NS = 45;
  localparam int T_RC_NS = 60;
  localparam int T_RCD_NS = 15;
  localparam int T_RTP_NS = 8;
  localparam int T_WTR_NS = 8;
  localparam int T_WR_NS = 15;
  localparam int T_RFC_NS = 130;
  localparam int T_REFI_NS = 7800;

  // least time in ns to whole cycles, never below one
  function automatic int dart_cyc(input int ns);
    int c;
    c = (ns + TCK_NS - 1) / TCK_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int RP_CYC = dart_cyc(T_RP_NS);
  localparam int RPALL_CYC = dart_cyc(T_RPALL_NS);
  localparam int RAS_CYC = dart_cyc(T_RAS_NS);
  localparam int RC_CYC = dart_cyc(T_RC_NS);
  localparam int RCD_CYC = dart_cyc(T_RCD_NS);
  localparam int RTP_CYC = dart_cyc(T_RTP_NS);
  localparam int WTR_CYC = dart_cyc(T_WTR_NS);
  localparam int WRA_CYC = dart_cyc(T_WR_NS);
  localparam int RFC_CYC = dart_cyc(T_RFC_NS);
  localparam int REFI_CYC = T_REFI_NS / TCK_NS;

  // spacing constants
  localparam int RTP_FLOOR = 2;
  localparam int RTP_OFFSET = 2;
  localparam int RD_WR_EXTRA = 2;
  localparam int PRE_GAP_CYC = 1;
  localparam int POSTED_MAX = 8;

  // {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_DESEL = 4'hF;
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_RD = 4'h5;
  localparam logic [3:0] CMD_WR = 4'h4;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_REF = 4'h1;

  typedef enum {C_NOP, C_ACT, C_RD, C_WR, C_PRE, C_REF, C_OTHER} dart_cmd_t;

  // pin pattern to command
  function automatic dart_cmd_t dart_decode(input logic [3:0] p);
    if (p[3])
      return C_NOP;
    unique case (p)
      CMD_NOP: return C_NOP;
      CMD_ACT: return C_ACT;
      CMD_RD: return C_RD;
      CMD_WR: return C_WR;
      CMD_PRE: return C_PRE;
      CMD_REF: return C_REF;
      default: return C_OTHER;
    endcase
  endfunction

  // the longer of two remaining waits
  function automatic logic [CNT_W-1:0] dart_later(
    input logic [CNT_W-1:0] a,
    input logic [CNT_W-1:0] b
  );
    return (a > b) ? a : b;
  endfunction
endpackage
`default_nettype wire

// ==== verif/dart_link_monitor.sv ====
// checker of command spacing on the pins between the two ends
// assumes one clock, async active-high reset, nop while idle
`default_nettype none
module dart_link_monitor #(
  parameter int CL = dart_pkg::CL_DEF,
  parameter int AL = dart_pkg::AL_DEF,
  parameter int BL = dart_pkg::BL_DEF,
  parameter int WR = dart_pkg::WR_DEF
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [dart_pkg::ADDR_W-1:0] addr,
  input wire logic [dart_pkg::BANK_W-1:0] ba
);
  import dart_pkg::*;
  localparam int WL = AL + CL - 1;
  localparam int RD_PRE = AL + BL / 2 + (RTP_CYC > 2 ? RTP_CYC : 2) - 2;
  localparam int WR_PRE = WL + BL / 2 + WRA_CYC;
  localparam int WA_PRE = WL + BL / 2 + WR;
  localparam int RP_MIN = RP_CYC < RPALL_CYC ? RP_CYC : RPALL_CYC;
  localparam int WTR_GAP = CL - 1 + BL / 2 + WTR_CYC;
  logic [3:0] pin;
  logic act, col, pre, refr;
  logic [7:0] age_q [NUM_BANKS];
  logic [7:0] pra_q [NUM_BANKS];
  logic [7:0] cage_q, lpa_q, rfc_q, open_q;
  logic [BANK_W-1:0] cba_q;
  logic cwr_q, cap_q;

  // pin decode
  assign pin = {cs_n, ras_n, cas_n, we_n};
  assign act = pin == CMD_ACT;
  assign col = pin == CMD_RD || pin == CMD_WR;
  assign pre = pin == CMD_PRE;
  assign refr = pin == CMD_REF;

  // saturating age step
  function automatic logic [7:0] up(input logic [7:0] v);
    return v == 8'hFF ? v : v + 8'h01;
  endfunction

  // per-bank ages since activate and precharge, open rows
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      open_q <= 8'h00;
      for (int b = 0; b < NUM_BANKS; b++)
      begin
        age_q[b] <= 8'hFF;
        pra_q[b] <= 8'hFF;
      end
    end
    else
    begin
      for (int b = 0; b < NUM_BANKS; b++)
      begin
        age_q[b] <= act && ba == b ? 8'h01 : up(age_q[b]);
        pra_q[b] <= pre && (addr[AP_BIT] || ba == b) ? 8'h01 : up(pra_q[b]);
        if (act && ba == b)
          open_q[b] <= 1'b1;
        else if ((pre || col && addr[AP_BIT]) && (addr[AP_BIT] || ba == b))
          open_q[b] <= 1'b0;
      end
    end

  // last column command, last precharge, refresh countdown
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      cage_q <= 8'hFF;
      lpa_q <= 8'hFF;
      rfc_q <= 8'h00;
      cba_q <= '0;
      cwr_q <= 1'b0;
      cap_q <= 1'b0;
    end
    else
    begin
      cage_q <= col ? 8'h01 : up(cage_q);
      lpa_q <= pre ? 8'h01 : up(lpa_q);
      rfc_q <= refr ? 8'(RFC_CYC - 1) : rfc_q != 8'h00 ? rfc_q - 8'h01 : rfc_q;
      if (col)
      begin
        cba_q <= ba;
        cwr_q <= !we_n;
        cap_q <= addr[AP_BIT];
      end
    end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  pre_spacing_a: assert property (pre |-> !$past(pre))
    else $error("precharges on adjacent edges");
  act_row_cycle_a: assert property (act |-> age_q[ba] >= RC_CYC)
    else $error("activate before row cycle time");
  act_rp_a: assert property (act |-> pra_q[ba] >= RP_MIN)
    else $error("activate inside precharge period");
  pre_after_col_a: assert property (pre && (addr[AP_BIT] || ba == cba_q)
    |-> cage_q >= (!cwr_q ? RD_PRE : cap_q ? WA_PRE : WR_PRE))
    else $error("precharge too soon after column");
  act_after_ap_a: assert property (act && cap_q && ba == cba_q
    |-> cage_q >= (cwr_q ? WA_PRE + RP_CYC : RD_PRE + RP_CYC))
    else $error("reopen too soon after auto-precharge");
  col_gap_a: assert property (col |-> cage_q >= (cwr_q && we_n ? WTR_GAP
    : !cwr_q && !we_n ? BL / 2 + 2 : BL / 2))
    else $error("column commands too close");
  ref_idle_a: assert property (refr
    |-> open_q == 8'h00 && lpa_q >= RP_MIN)
    else $error("refresh with a bank not idle");
  ref_cycle_a: assert property ((act || refr) |-> rfc_q == 8'h00)
    else $error("command inside refresh cycle time");
endmodule
`default_nettype wire

// ==== verif/dart_tb.sv ====
// bench: controller end drives memory end, a model checks results
// assumes 100 MHz clock and the shared command interface
`default_nettype none
module dart_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import dart_pkg::*;
  localparam int WRV = 4;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic req_ap = 1'b0;
  logic [BANK_W-1:0] req_bank = '0;
  logic [ADDR_W-1:0] req_row = '0;
  logic [COL_W-1:0] req_col = '0;
  logic req_ack, col_issued;
  logic [DEBT_W-1:0] refresh_debt;
  logic [NUM_BANKS-1:0] bank_active, bank_idle;
  logic [ADDR_W-1:0] refresh_row;
  logic refresh_busy, ap_fired;
  logic ref_d = 1'b0;
  int nap = 0;
  logic [28:0] f;
  logic [28:0] exp_q[$];
  int error_cnt = 0;
  int check_count = 0;
  int cyc = 0;
  int gap = 0;
  int nref = 0;
  wire [3:0] pin;

  dart_if link ();
  assign pin = {link.cs_n, link.ras_n, link.cas_n, link.we_n};
  dart_ctrl_end #(.CL(CL_DEF), .AL(AL_DEF), .BL(BL_DEF), .WR(WRV))
    dart_ctrl_end_inst (.clk(clk), .rst(rst), .link(link),
    .req_valid(req_valid), .req_write(req_write), .req_ap(req_ap),
    .req_bank(req_bank), .req_row(req_row), .req_col(req_col),
    .req_ack(req_ack), .col_issued(col_issued),
    .refresh_debt(refresh_debt));
  dart_dram_end #(.CL(CL_DEF), .AL(AL_DEF), .BL(BL_DEF), .WR(WRV))
    dart_dram_end_inst (.clk(clk), .rst(rst), .link(link),
    .bank_active(bank_active), .bank_idle(bank_idle),
    .refresh_row(refresh_row), .refresh_busy(refresh_busy),
    .ap_fired(ap_fired));
  dart_link_monitor #(.CL(CL_DEF), .AL(AL_DEF), .BL(BL_DEF), .WR(WRV))
    dart_link_monitor_inst (.clk(clk), .rst(rst), .cs_n(link.cs_n),
    .ras_n(link.ras_n), .cas_n(link.cas_n), .we_n(link.we_n),
    .addr(link.addr), .ba(link.ba));

  // clock
  always #5 clk = ~clk;

  // one compare of expected against seen
  task automatic chk(input string nm, input logic [15:0] e, g);
    check_count++;
    if (e !== g)
    begin
      error_cnt++;
      $display("MISMATCH %s exp %0h got %0h", nm, e, g);
    end
  endtask

  // counts, verdict, end of run
  task automatic wrap_up();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // hand one request over and hold it until taken
  task automatic send(input logic w, ap, input logic [2:0] b,
    input logic [13:0] r, input logic [9:0] c);
    req_valid <= 1'b1;
    req_write <= w;
    req_ap <= ap;
    req_bank <= b;
    req_row <= r;
    req_col <= c;
    exp_q.push_back({w, ap, b, r, c});
    for (int i = 0; i < 400; i++)
    begin
      @(posedge clk);
      if (req_ack === 1'b1)
        break;
    end
  endtask

  // model: every activate, column command and refresh on the pins
  always @(posedge clk)
  begin
    cyc++;
    if (cyc > 40000)
    begin
      error_cnt++;
      wrap_up();
    end
    else if (!rst)
    begin
      gap++;
      if (ap_fired === 1'b1)
        nap++;
      if (ref_d)
      begin
        chk("refresh busy", 16'h1, 16'(refresh_busy));
        chk("refresh row", 16'(nref), 16'(refresh_row));
        chk("open banks", 16'h0, 16'(bank_active));
      end
      ref_d = pin == CMD_REF;
      if (ref_d)
      begin
        chk("refresh gap", 16'h1, 16'(gap <= 9 * REFI_CYC));
        nref++;
        gap = 0;
      end
      if (pin == CMD_ACT)
      begin
        f = exp_q[0];
        chk("act bank", 16'(f[26:24]), 16'(link.ba));
        chk("act row", 16'(f[23:10]), 16'(link.addr));
      end
      if (col_issued === 1'b1)
      begin
        f = exp_q.pop_front();
        chk("col cmd", 16'(f[28] ? CMD_WR : CMD_RD), 16'(pin));
        chk("col bank", 16'(f[26:24]), 16'(link.ba));
        chk("col ap", 16'({f[27], f[9:0]}), 16'(link.addr[10:0]));
      end
    end
  end

  initial
  begin
    void'($urandom(52));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // each mix of write and auto-precharge, then the row state
    for (int k = 0; k < 4; k++)
    begin
      send(k[0], k[1], 3'(k + 1), 14'(k), 10'(3 * k));
      req_valid <= 1'b0;
      repeat (30) @(posedge clk);
      chk("row open", 16'(!k[1]), 16'(bank_active[k + 1]));
    end
    chk("ap fired", 16'h2, 16'(nap));
    // unbroken random traffic so refreshes get posted
    for (int n = 0; n < 900; n++)
      send(1'($urandom), 1'($urandom), 3'($urandom), 14'($urandom % 3),
        10'($urandom));
    req_valid <= 1'b0;
    repeat (3000) @(posedge clk);
    chk("debt paid", 16'h1, 16'(refresh_debt <= 1));
    wrap_up();
  end
endmodule
`default_nettype wire
